// File: verilog/cdfi_top.v
// card data fifo, status flags, interrupt masks and power control register
//
// Contract
// - tx fifo stores each bus write to the fifo window at write pointer, pointer advances per write
// - tx fifo presents word at read pointer; pointer advances on shift-register load
// - tx disabled: tx flags low, tx pointers back to reset
// - tx full flag high exactly when all 16 words valid
// - tx half-empty high when 8 or more words empty; serves as dma request
// - tx empty when nothing held; tx data-available is its inverse
// - tx underrun is sticky until the clear register is written
// - rx strobe writes word, advances write pointer, returns acknowledge
// - rx word at read pointer goes to bus read data; pops on bus acknowledge
// - rx disabled: rx flags low, rx pointers back to reset
// - rx full flag high exactly when all 16 words valid
// - rx half-full high when 8 or more words valid; serves as dma request
// - rx data-available high when not empty, inverse of rx empty
// - rx overrun is sticky until the clear register is written
// - transmit active from data path selects the buffer as tx fifo
// - receive active from data path selects the buffer as rx fifo
// - two interrupt lines, each the or of status anded with its own mask
// - power field: 00 off, 10 up, 11 on, 01 reserved; bit 6 driver mode
// - card bus outputs disabled while power is in up or on phase
// - one shared buffer, 32 bits wide, 16 words deep
// - tx and rx active never both high; both low disables the fifo
`default_nettype none
`include "cdfi_map.vh"

// ---------------------------------------------------------------
// shared buffer
// ---------------------------------------------------------------
module cdfi_fifo #(
  parameter WIDTH = 32,
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  input  wire             mclk,
  input  wire             rst_b,
  input  wire             clear,
  input  wire             inValid,
  output wire             inReady,
  input  wire [WIDTH-1:0] inData,
  output wire             outValid,
  input  wire             outReady,
  output wire [WIDTH-1:0] outData,
  output wire [AW:0]      level
);
  localparam [AW:0] FULLV = DEPTH[AW:0];

  reg  [AW-1:0]          wrPtr_q;
  reg  [AW-1:0]          rdPtr_q;
  reg  [AW:0]            level_q;
  wire [WIDTH*DEPTH-1:0] flat;
  wire                   push;
  wire                   pop;

  assign inReady  = (level_q != FULLV);
  assign outValid = (level_q != {(AW+1){1'b0}});
  assign push     = inValid & inReady;
  assign pop      = outValid & outReady;
  assign level    = level_q;
  assign outData  = flat[rdPtr_q*WIDTH +: WIDTH];

  genvar i;
  generate
    for (i = 0; i < DEPTH; i = i + 1) begin : g_word
      reg [WIDTH-1:0] word_q;
      always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
          word_q <= {WIDTH{1'b0}};
        end else if (push && (wrPtr_q == i)) begin
          word_q <= inData;
        end
      end
      assign flat[i*WIDTH +: WIDTH] = word_q;
    end
  endgenerate

  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      wrPtr_q <= {AW{1'b0}};
      rdPtr_q <= {AW{1'b0}};
      level_q <= {(AW+1){1'b0}};
    end else if (clear) begin
      wrPtr_q <= {AW{1'b0}};
      rdPtr_q <= {AW{1'b0}};
      level_q <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wrPtr_q <= wrPtr_q + {{(AW-1){1'b0}}, 1'b1};
      end
      if (pop) begin
        rdPtr_q <= rdPtr_q + {{(AW-1){1'b0}}, 1'b1};
      end
      if (push && !pop) begin
        level_q <= level_q + {{AW{1'b0}}, 1'b1};
      end else if (pop && !push) begin
        level_q <= level_q - {{AW{1'b0}}, 1'b1};
      end
    end
  end
endmodule // cdfi_fifo

// ---------------------------------------------------------------
// top level
// ---------------------------------------------------------------
module cdfi_top (
  input  wire        mclk,
  input  wire        rst_b,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [31:0] paddr,
  input  wire [31:0] pwdata,
  output wire [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  input  wire        transmitActive,
  input  wire        receiveActive,
  input  wire        txLoad,
  output wire [31:0] txWord,
  output wire        txWordValid,
  input  wire        rxStrobe,
  input  wire [31:0] rxWord,
  output wire        rxAck,
  output wire        irq0,
  output wire        irq1,
  output wire        txDmaReq,
  output wire        rxDmaReq,
  output wire [1:0]  powerPhase,
  output wire        cmdLineDriverMode,
  output wire        cardBusOutputsDisabled,
  output wire        cardPowerEnablePin,
  output wire        cardIfClockGate
);

  // ---------------------------------------------------------------
  // address decode
  // ---------------------------------------------------------------
  function winHit;
    input [31:0] a;
    begin
      winHit = (a >= `CDFI_A_WIN_LO) && (a <= `CDFI_A_WIN_HI) && (a[1:0] == 2'h0);
    end
  endfunction

  function mapped;
    input [31:0] a;
    begin
      case (a)
        `CDFI_A_CLKGATE, `CDFI_A_POWER, `CDFI_A_CLKCTL, `CDFI_A_ARG,
        `CDFI_A_CMD, `CDFI_A_RESPCMD, `CDFI_A_RESP0, `CDFI_A_RESP1,
        `CDFI_A_RESP2, `CDFI_A_RESP3, `CDFI_A_TIMER, `CDFI_A_LENGTH,
        `CDFI_A_DCTL, `CDFI_A_DCNT, `CDFI_A_STATUS, `CDFI_A_CLEAR,
        `CDFI_A_MASK0, `CDFI_A_MASK1, `CDFI_A_FIFOCNT: mapped = 1'b1;
        default: mapped = winHit(a);
      endcase
    end
  endfunction

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  reg  [7:0]          power_q;
  reg                 clkGate_q;
  reg  [11:0]         clkCtl_q;
  reg  [31:0]         arg_q;
  reg  [10:0]         cmd_q;
  reg  [31:0]         timer_q;
  reg  [15:0]         length_q;
  reg  [7:0]          dataCtl_q;
  reg  [21:0]         mask0_q;
  reg  [21:0]         mask1_q;
  reg                 txUnder_q;
  reg                 rxOver_q;
  reg  [31:0]         prdata_q;
  reg  [31:0]         rdMux;

  wire                txMode;
  wire                rxMode;
  wire                access;
  wire                wrAcc;
  wire                winWr;
  wire                winRd;
  wire                fifoInValid;
  wire                fifoInReady;
  wire [31:0]         fifoInData;
  wire                fifoOutValid;
  wire                fifoOutReady;
  wire [31:0]         fifoOutData;
  wire [4:0]          level;
  wire                full;
  wire                empty;
  wire                halfFull;
  wire                halfEmpty;
  wire                underEvt;
  wire                overEvt;
  wire                clrWr;
  wire [`CDFI_ST_W-1:0] status;

  assign txMode = transmitActive & ~receiveActive;
  assign rxMode = receiveActive & ~transmitActive;

  // ---------------------------------------------------------------
  // bus slave
  // ---------------------------------------------------------------
  assign access  = psel & penable;
  assign winWr   = access & pwrite & winHit(paddr);
  assign winRd   = access & ~pwrite & winHit(paddr);
  assign pready  = ~(winWr & txMode & ~fifoInReady);
  assign wrAcc   = access & pwrite & pready;
  assign pslverr = access & ~mapped(paddr);
  assign prdata  = prdata_q;
  assign clrWr   = wrAcc & (paddr == `CDFI_A_CLEAR);

  // ---------------------------------------------------------------
  // fifo routing
  // ---------------------------------------------------------------
  assign fifoInValid  = txMode ? (winWr & pwrite) : (rxMode & rxStrobe);
  assign fifoInData   = txMode ? pwdata : rxWord;
  assign fifoOutReady = txMode ? txLoad : (rxMode & winRd);
  assign rxAck        = rxMode & rxStrobe & fifoInReady;
  assign txWord       = fifoOutData;
  assign txWordValid  = txMode & fifoOutValid;

  cdfi_fifo #(
    .WIDTH (`CDFI_FIFO_WIDTH),
    .DEPTH (`CDFI_FIFO_DEPTH),
    .AW    (`CDFI_FIFO_AW)
  ) u_fifo (
    .mclk     (mclk),
    .rst_b    (rst_b),
    .clear    (~(txMode | rxMode)),
    .inValid  (fifoInValid),
    .inReady  (fifoInReady),
    .inData   (fifoInData),
    .outValid (fifoOutValid),
    .outReady (fifoOutReady),
    .outData  (fifoOutData),
    .level    (level)
  );

  // ---------------------------------------------------------------
  // flags
  // ---------------------------------------------------------------
  assign full      = ~fifoInReady;
  assign empty     = ~fifoOutValid;
  assign halfFull  = (level >= `CDFI_HALF_MARK);
  assign halfEmpty = (level <= `CDFI_HALF_MARK);
  assign underEvt  = txMode & txLoad & empty;
  assign overEvt   = rxMode & rxStrobe & full;
  assign txDmaReq  = txMode & halfEmpty;
  assign rxDmaReq  = rxMode & halfFull;

  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      txUnder_q <= 1'b0;
      rxOver_q  <= 1'b0;
    end else begin
      if (underEvt) begin
        txUnder_q <= 1'b1;
      end else if (clrWr && pwdata[`CDFI_CLR_TXUNDER]) begin
        txUnder_q <= 1'b0;
      end
      if (overEvt) begin
        rxOver_q <= 1'b1;
      end else if (clrWr && pwdata[`CDFI_CLR_RXOVER]) begin
        rxOver_q <= 1'b0;
      end
    end
  end

  // tx flags show only in tx mode, rx flags only in rx mode
  assign status[`CDFI_ST_TXUNDER] = txMode & txUnder_q;
  assign status[`CDFI_ST_RXOVER]  = rxMode & rxOver_q;
  assign status[`CDFI_ST_TXACT]   = txMode;
  assign status[`CDFI_ST_RXACT]   = rxMode;
  assign status[`CDFI_ST_TXFULL]  = txMode & full;
  assign status[`CDFI_ST_RXFULL]  = rxMode & full;
  assign status[`CDFI_ST_TXHALF]  = txMode & halfEmpty;
  assign status[`CDFI_ST_RXHALF]  = rxMode & halfFull;
  assign status[`CDFI_ST_TXEMPTY] = txMode & empty;
  assign status[`CDFI_ST_RXEMPTY] = rxMode & empty;
  assign status[`CDFI_ST_TXAVAIL] = txMode & ~empty;
  assign status[`CDFI_ST_RXAVAIL] = rxMode & ~empty;
  assign status[`CDFI_ST_W-1:12]  = 10'h000;

  assign irq0 = |(status & mask0_q);
  assign irq1 = |(status & mask1_q);

  // ---------------------------------------------------------------
  // power control
  // ---------------------------------------------------------------
  assign powerPhase             = power_q[1:0];
  assign cmdLineDriverMode      = power_q[`CDFI_PWR_DRVBIT];
  assign cardBusOutputsDisabled = (power_q[1:0] == `CDFI_PWR_UP) |
                                  (power_q[1:0] == `CDFI_PWR_ON);
  assign cardPowerEnablePin     = power_q[1];
  assign cardIfClockGate        = clkGate_q;

  // ---------------------------------------------------------------
  // register writes
  // ---------------------------------------------------------------
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      power_q   <= 8'h00;
      clkGate_q <= 1'b0;
      clkCtl_q  <= 12'h000;
      arg_q     <= 32'h00000000;
      cmd_q     <= 11'h000;
      timer_q   <= 32'h00000000;
      length_q  <= 16'h0000;
      dataCtl_q <= 8'h00;
      mask0_q   <= 22'h000000;
      mask1_q   <= 22'h000000;
    end else if (wrAcc) begin
      case (paddr)
        `CDFI_A_POWER: begin
          power_q <= {1'b0, pwdata[`CDFI_PWR_DRVBIT], 4'h0, pwdata[1:0]};
        end
        `CDFI_A_CLKGATE: clkGate_q <= pwdata[0];
        `CDFI_A_CLKCTL:  clkCtl_q  <= pwdata[11:0];
        `CDFI_A_ARG:     arg_q     <= pwdata;
        `CDFI_A_CMD:     cmd_q     <= pwdata[10:0];
        `CDFI_A_TIMER:   timer_q   <= pwdata;
        `CDFI_A_LENGTH:  length_q  <= pwdata[15:0];
        `CDFI_A_DCTL:    dataCtl_q <= pwdata[7:0];
        `CDFI_A_MASK0:   mask0_q   <= pwdata[21:0];
        `CDFI_A_MASK1:   mask1_q   <= pwdata[21:0];
        default: begin
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // read data, captured in the setup phase
  // ---------------------------------------------------------------
  always @* begin
    rdMux = 32'h00000000;
    if (winHit(paddr)) begin
      rdMux = fifoOutData;
    end else begin
      case (paddr)
        `CDFI_A_POWER:   rdMux = {24'h000000, power_q};
        `CDFI_A_CLKGATE: rdMux = {31'h00000000, clkGate_q};
        `CDFI_A_CLKCTL:  rdMux = {20'h00000, clkCtl_q};
        `CDFI_A_ARG:     rdMux = arg_q;
        `CDFI_A_CMD:     rdMux = {21'h000000, cmd_q};
        `CDFI_A_TIMER:   rdMux = timer_q;
        `CDFI_A_LENGTH:  rdMux = {16'h0000, length_q};
        `CDFI_A_DCTL:    rdMux = {24'h000000, dataCtl_q};
        `CDFI_A_STATUS:  rdMux = {10'h000, status};
        `CDFI_A_MASK0:   rdMux = {10'h000, mask0_q};
        `CDFI_A_MASK1:   rdMux = {10'h000, mask1_q};
        `CDFI_A_FIFOCNT: rdMux = {27'h0000000, level};
        default:         rdMux = 32'h00000000;
      endcase
    end
  end

  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      prdata_q <= 32'h00000000;
    end else if (psel && !penable && !pwrite) begin
      prdata_q <= rdMux;
    end
  end

endmodule // cdfi_top
`default_nettype wire

// File: verilog/cdfi_map.vh
// register offsets, field positions and fifo parameters of the card data fifo block
`ifndef CDFI_MAP_VH
`define CDFI_MAP_VH

`define CDFI_A_CLKGATE  32'h8000502c
`define CDFI_A_POWER    32'h80100000
`define CDFI_A_CLKCTL   32'h80100004
`define CDFI_A_ARG      32'h80100008
`define CDFI_A_CMD      32'h8010000c
`define CDFI_A_RESPCMD  32'h80100010
`define CDFI_A_RESP0    32'h80100014
`define CDFI_A_RESP1    32'h80100018
`define CDFI_A_RESP2    32'h8010001c
`define CDFI_A_RESP3    32'h80100020
`define CDFI_A_TIMER    32'h80100024
`define CDFI_A_LENGTH   32'h80100028
`define CDFI_A_DCTL     32'h8010002c
`define CDFI_A_DCNT     32'h80100030
`define CDFI_A_STATUS   32'h80100034
`define CDFI_A_CLEAR    32'h80100038
`define CDFI_A_MASK0    32'h8010003c
`define CDFI_A_MASK1    32'h80100040
`define CDFI_A_FIFOCNT  32'h80100048
`define CDFI_A_WIN_LO   32'h80100080
`define CDFI_A_WIN_HI   32'h801000bc

`define CDFI_FIFO_WIDTH 32
`define CDFI_FIFO_DEPTH 16
`define CDFI_FIFO_AW    4
`define CDFI_HALF_MARK  5'h08

`define CDFI_PWR_OFF    2'h0
`define CDFI_PWR_RSVD   2'h1
`define CDFI_PWR_UP     2'h2
`define CDFI_PWR_ON     2'h3
`define CDFI_PWR_DRVBIT 6

`define CDFI_ST_TXUNDER 0
`define CDFI_ST_RXOVER  1
`define CDFI_ST_TXACT   2
`define CDFI_ST_RXACT   3
`define CDFI_ST_TXFULL  4
`define CDFI_ST_RXFULL  5
`define CDFI_ST_TXHALF  6
`define CDFI_ST_RXHALF  7
`define CDFI_ST_TXEMPTY 8
`define CDFI_ST_RXEMPTY 9
`define CDFI_ST_TXAVAIL 10
`define CDFI_ST_RXAVAIL 11
`define CDFI_ST_W       22

`define CDFI_CLR_TXUNDER 0
`define CDFI_CLR_RXOVER  1

`endif

// File: verification/cdfi_top_properties.sv
// concurrent checks on the ports of the card data fifo block
`default_nettype none
// ---------------------------------------------------------------
// checker
// ---------------------------------------------------------------
module cdfi_top_properties (
  input wire logic        mclk,
  input wire logic        rst_b,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        transmitActive,
  input wire logic        receiveActive,
  input wire logic        txLoad,
  input wire logic        txWordValid,
  input wire logic        rxStrobe,
  input wire logic        rxAck,
  input wire logic        txDmaReq,
  input wire logic        rxDmaReq,
  input wire logic [1:0]  powerPhase,
  input wire logic        cardBusOutputsDisabled,
  input wire logic        cardPowerEnablePin
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);
  wire logic       apbWr   = psel && penable && pwrite && pready;
  wire logic [1:0] wrPhase = pwdata[1:0];
  wire logic       offMode = !(transmitActive ^ receiveActive);

  a_rx_ack_cause: assert property (rxAck |-> rxStrobe && receiveActive && !transmitActive)
    else $error("rx acknowledge without an accepted strobe");
  a_tx_valid_mode: assert property (txWordValid |-> transmitActive && !receiveActive)
    else $error("tx word valid outside tx mode");
  a_off_flags_low: assert property (offMode [*2] |-> !txDmaReq && !rxDmaReq)
    else $error("dma request while fifo disabled");
  a_pwr_pins: assert property (cardPowerEnablePin == powerPhase[1] &&
    cardBusOutputsDisabled == powerPhase[1])
    else $error("power pins disagree with phase");
  a_pwr_write: assert property (apbWr && paddr == 32'h80100000 |=>
    powerPhase == $past(wrPhase))
    else $error("power phase not taken from write");
  a_unmapped_err: assert property (psel && penable && paddr == 32'h80100044 |-> pslverr)
    else $error("no error on unmapped access");
  a_stall_cause: assert property (!pready |-> psel && penable && pwrite && !txDmaReq &&
    transmitActive && !receiveActive)
    else $error("wait state without full tx fifo");
  a_stall_release: assert property (!pready && txLoad |=> pready)
    else $error("stall held after shift register load");
  a_rx_half_rise: assert property ($rose(rxDmaReq) |-> $past(rxAck))
    else $error("rx half full rose without a write");
  a_tx_fresh_empty: assert property (transmitActive && !receiveActive &&
    !$past(transmitActive) && !$past(receiveActive) |-> txDmaReq && !txWordValid)
    else $error("fresh tx fifo not empty");
endmodule // cdfi_top_properties

bind cdfi_top cdfi_top_properties u_props (.mclk(mclk), .rst_b(rst_b), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
  .pslverr(pslverr), .transmitActive(transmitActive), .receiveActive(receiveActive),
  .txLoad(txLoad), .txWordValid(txWordValid), .rxStrobe(rxStrobe), .rxAck(rxAck),
  .txDmaReq(txDmaReq), .rxDmaReq(rxDmaReq), .powerPhase(powerPhase),
  .cardBusOutputsDisabled(cardBusOutputsDisabled), .cardPowerEnablePin(cardPowerEnablePin));
`default_nettype wire

// File: verification/cdfi_dp_model.sv
// data path model: mode levels, shift register loads and receive strobes
`default_nettype none
// ---------------------------------------------------------------
// data path model
// ---------------------------------------------------------------
module cdfi_dp_model (
  input  wire logic        mclk,
  input  wire logic [31:0] txWord,
  input  wire logic        txWordValid,
  input  wire logic        rxAck,
  output logic             transmitActive,
  output logic             receiveActive,
  output logic             txLoad,
  output logic             rxStrobe,
  output logic [31:0]      rxWord
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    transmitActive = 1'b0;
    receiveActive  = 1'b0;
    txLoad         = 1'b0;
    rxStrobe       = 1'b0;
    rxWord         = 32'h0;
  end
  // the two modes are only ever entered one at a time
  task setMode(input logic t, input logic r);
    @(posedge mclk) #1;
    transmitActive = t;
    receiveActive  = r;
  endtask
  task load(output logic [31:0] w, output logic v);
    @(posedge mclk) #1;
    w = txWord;
    v = txWordValid;
    txLoad = 1'b1;
    @(posedge mclk) #1;
    txLoad = 1'b0;
  endtask
  // released data shows the inverse, never the last value
  task strobe(input logic [31:0] d, output logic a);
    @(posedge mclk) #1;
    rxWord = d;
    rxStrobe = 1'b1;
    #1 a = rxAck;
    @(posedge mclk) #1;
    rxStrobe = 1'b0;
    rxWord = ~d;
  endtask
endmodule // cdfi_dp_model
`default_nettype wire

// File: verification/tb.sv
// self-checking bench of the card data fifo block
`default_nettype none
// ---------------------------------------------------------------
// bench
// ---------------------------------------------------------------
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] AST = 32'h80100034;
  localparam logic [31:0] AWIN = 32'h80100080;
  logic        mclk, rst_b, psel, penable, pwrite, pready, pslverr, irq0, irq1;
  logic [31:0] paddr, pwdata, prdata, txWord, rxWord, w;
  logic        transmitActive, receiveActive, txLoad, txWordValid, rxStrobe, rxAck, v;
  logic        txDmaReq, rxDmaReq, cmdLineDriverMode, cardBusOutputsDisabled;
  logic        cardPowerEnablePin, cardIfClockGate;
  logic [1:0]  powerPhase;
  logic [31:0] expQ[$];
  logic [31:0] dataQ[$];
  int          numErrors, nTests, lvl;

  cdfi_top u_dut (.mclk(mclk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .transmitActive(transmitActive), .receiveActive(receiveActive), .txLoad(txLoad),
    .txWord(txWord), .txWordValid(txWordValid), .rxStrobe(rxStrobe), .rxWord(rxWord),
    .rxAck(rxAck), .irq0(irq0), .irq1(irq1), .txDmaReq(txDmaReq), .rxDmaReq(rxDmaReq),
    .powerPhase(powerPhase), .cmdLineDriverMode(cmdLineDriverMode),
    .cardBusOutputsDisabled(cardBusOutputsDisabled), .cardPowerEnablePin(cardPowerEnablePin),
    .cardIfClockGate(cardIfClockGate));
  cdfi_dp_model u_dp (.mclk(mclk), .txWord(txWord), .txWordValid(txWordValid), .rxAck(rxAck),
    .transmitActive(transmitActive), .receiveActive(receiveActive), .txLoad(txLoad),
    .rxStrobe(rxStrobe), .rxWord(rxWord));

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  task check(input logic [31:0] seen, input logic [31:0] exp);
    nTests++;
    if (seen !== exp) begin
      numErrors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task testDone;
    if (numErrors == 0 && nTests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // one apb transfer; a read leaves its expected data for the monitor
  task apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
    int n;
    if (!wr) expQ.push_back(d);
    @(posedge mclk) #1;
    psel = 1'b1;
    pwrite = wr;
    paddr = a;
    pwdata = wr ? d : ~d;
    @(posedge mclk) #1;
    penable = 1'b1;
    n = 0;
    // pready is sampled at the edge that would complete the access
    @(posedge mclk);
    while (pready !== 1'b1) begin
      n++;
      if (n > 60) begin
        numErrors++;
        testDone;
      end
      @(posedge mclk);
    end
    #1;
    psel = 1'b0;
    penable = 1'b0;
  endtask

  always @(posedge mclk) begin
    if (psel && penable && !pwrite && pready === 1'b1) check(prdata, expQ.pop_front());
  end

  function automatic logic [31:0] stat(input logic t, input logic r, input logic e);
    logic [31:0] s;
    int b;
    b = r;
    s = 32'h0;
    if (t != r) begin
      s[b] = e;
      s[2+b] = 1'b1;
      s[4+b] = lvl == 16;
      s[6+b] = r ? lvl >= 8 : lvl <= 8;
      s[8+b] = lvl == 0;
      s[10+b] = lvl != 0;
    end
    stat = s;
  endfunction

  initial begin
    {psel, penable, pwrite, rst_b} = 4'h0;
    paddr = 32'h0;
    pwdata = 32'h0;
    numErrors = 0;
    nTests = 0;
    lvl = 0;
    void'($urandom(84));
    repeat (2) @(posedge mclk);
    #1 rst_b = 1'b1;
    for (int i = 0; i < 7; i++) begin
      apb(1'b0, 32'h80100000 + 32'(i) * 32'h4 + (i > 4 ? 32'h28 : 32'h0), 32'h0);
    end
    apb(1'b0, 32'h80100044, 32'h0);
    apb(1'b1, 32'h8000502c, 32'h1);
    check({31'h0, cardIfClockGate}, 32'h1);
    for (int i = 0; i < 5; i++) begin
      apb(1'b1, 32'h80100000, {25'h0, i[0], 4'h0, i[1:0]});
      repeat (10) @(posedge mclk);
      check({30'h0, cardBusOutputsDisabled, cardPowerEnablePin}, {30'h0, i[1], i[1]});
      check({31'h0, cmdLineDriverMode}, {31'h0, i[0]});
      apb(1'b0, 32'h80100000, {25'h0, i[0], 4'h0, i[1:0]});
    end
    u_dp.setMode(1'b1, 1'b0);
    apb(1'b0, AST, stat(1'b1, 1'b0, 1'b0));
    for (int i = 0; i < 16; i++) begin
      w = $urandom;
      dataQ.push_back(w);
      apb(1'b1, AWIN + 32'(i) * 32'h4, w);
      lvl++;
      if (i inside {7, 8, 15}) apb(1'b0, AST, stat(1'b1, 1'b0, 1'b0));
    end
    w = $urandom;
    dataQ.push_back(w);
    fork
      apb(1'b1, AWIN, w);
      begin
        repeat (4) @(posedge mclk);
        u_dp.load(w, v);
        check(w, dataQ.pop_front());
      end
    join
    apb(1'b0, 32'h80100048, 32'h10);
    for (int i = 0; i < 16; i++) begin
      u_dp.load(w, v);
      check(w, dataQ.pop_front());
      check({31'h0, v}, 32'h1);
      lvl--;
      if (lvl == 8) apb(1'b0, AST, stat(1'b1, 1'b0, 1'b0));
    end
    u_dp.load(w, v);
    check({31'h0, v}, 32'h0);
    apb(1'b0, AST, stat(1'b1, 1'b0, 1'b1));
    apb(1'b1, 32'h8010003c, 32'h1);
    check({30'h0, irq1, irq0}, 32'h1);
    apb(1'b1, 32'h80100038, 32'h1);
    apb(1'b0, AST, stat(1'b1, 1'b0, 1'b0));
    check({30'h0, irq1, irq0}, 32'h0);
    u_dp.setMode(1'b0, 1'b0);
    apb(1'b0, AST, 32'h0);
    u_dp.setMode(1'b0, 1'b1);
    for (int i = 0; i < 17; i++) begin
      w = $urandom;
      u_dp.strobe(w, v);
      check({31'h0, v}, {31'h0, i < 16});
      if (i < 16) dataQ.push_back(w);
      if (i < 16) lvl++;
      if (i == 7) apb(1'b0, AST, stat(1'b0, 1'b1, 1'b0));
    end
    apb(1'b0, AST, stat(1'b0, 1'b1, 1'b1));
    apb(1'b1, 32'h80100040, 32'h2);
    check({30'h0, irq1, irq0}, 32'h2);
    for (int i = 0; i < 16; i++) begin
      apb(1'b0, AWIN + 32'(i) * 32'h4, dataQ.pop_front());
      lvl--;
      if (lvl == 8 || lvl == 7) apb(1'b0, AST, stat(1'b0, 1'b1, 1'b1));
    end
    apb(1'b1, 32'h80100038, 32'h2);
    apb(1'b0, AST, stat(1'b0, 1'b1, 1'b0));
    u_dp.setMode(1'b0, 1'b0);
    apb(1'b0, AST, 32'h0);
    testDone;
  end
endmodule // tb
`default_nettype wire
